/* include/touch_pkg.sv */
// Shared constants and types for the touch button output logic.
// Assumes a 125 MHz reference clock on both ends.
package touch_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int NUM_BUTTONS = 10; // Sense inputs and button outputs
    localparam int NUM_HOST_OUT = 4; // Host-driven output slots

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam longint CLK_HZ = 125000000; // Reference clock rate
    localparam int POWER_PULSE_MS = 16; // Power-on pulse length
    localparam longint POWER_PULSE_CYCLES =
        (CLK_HZ * POWER_PULSE_MS) / 1000;
    localparam int STUCK_SHORT_S = 5; // Short stuck-release period
    localparam int STUCK_LONG_S = 20; // Long stuck-release period
    localparam longint STUCK_SHORT_CYCLES = CLK_HZ * STUCK_SHORT_S;
    localparam longint STUCK_LONG_CYCLES = CLK_HZ * STUCK_LONG_S;
    localparam int CNT_W = 32; // Width of the long counters

    // ****************************************************************
    // Reset values and encodings
    // ****************************************************************
    localparam logic [3:0] HOST_OUT_RESET = 4'h0; // All low at power-on
    localparam logic [7:0] THRESH_RESET = 8'h40; // Fixed threshold default

    // Sounder configuration
    typedef enum logic [1:0] {
        SOUNDER_NONE,
        SOUNDER_ONE_PIN,
        SOUNDER_TWO_PIN
    } sounder_mode_e;

    // Device operating mode
    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_LINE_TEST,
        MODE_DEBUG,
        MODE_CONFIG
    } op_mode_e;

endpackage : touch_pkg

/* include/touch_link_if.sv */
// Link between touch device and host: open-drain wake line, host pins.
// Assumes an external pull-up: the line is high unless an end pulls it.
interface touch_link_if;
    logic dev_wake_oe; // Device pulls wake line low
    logic host_wake_oe; // Host pulls wake line low
    logic wake_line; // Resolved level with pull-up
    logic i2c_req; // Host starts an access (abstracted bus)
    logic i2c_ack; // Device acknowledges the access
    logic i2c_wr; // Access writes host outputs
    logic [3:0] i2c_wdata; // Host output value written
    logic [9:0] i2c_rdata; // Button status read back

    // Wire-AND of the two pull-downs
    assign wake_line = ~(dev_wake_oe | host_wake_oe);

    modport device (
        input wake_line, i2c_req, i2c_wr, i2c_wdata,
        output dev_wake_oe, i2c_ack, i2c_rdata
    );
    modport host (
        input wake_line, i2c_ack, i2c_rdata,
        output host_wake_oe, i2c_req, i2c_wr, i2c_wdata
    );
endinterface : touch_link_if

/* verilog/touch_device.sv */
// Device end: button outputs, host-driven outputs, wake line.
// Assumes sense shifts arrive from a front end on the reference clock.
// Behaviour
// (RULE1) Host outputs push-pull, level from last write
// (RULE2) Sounder mode sets 4, 3 or 2 outputs
// (RULE3) Host control in normal, test, debug modes
// (RULE4) Host outputs low after reset, not stored
// (RULE5) Second host output pulses 16 ms at power-on
// (RULE6) Wake line open-drain, pulled low only
// (RULE7) Host pulls wake low before any access
// (RULE8) Wake high means sleep; accesses may NACK
// (RULE9) Wake low means accesses are answered
// (RULE10) Device pulls wake low while any touched
// (RULE11) Host watches both edges or polls
// (RULE12) Stuck touch forced off after 5/20 s
// (RULE13) Touch by shift against fixed or auto threshold
// (RULE14) Toggle mode inverts output on each touch
// (RULE15) Suppression group allows one touched button
// (RULE16) Buttons outside group evaluated independently
// (RULE17) Button outputs active low per sense input
// (RULE18) Forced-off button waits for release first
module touch_device #(
    parameter longint STUCK_SHORT = touch_pkg::STUCK_SHORT_CYCLES,
    parameter longint STUCK_LONG = touch_pkg::STUCK_LONG_CYCLES,
    parameter longint PULSE_LEN = touch_pkg::POWER_PULSE_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    touch_link_if.device link,
    input wire logic [9:0][7:0] shift_in,
    input wire logic [7:0] noise_in,
    input wire logic auto_thresh_in,
    input wire logic [7:0] fixed_thresh_in,
    input wire logic [9:0] toggle_en_in,
    input wire logic [9:0] suppress_en_in,
    input wire logic stuck_long_in,
    input wire logic [1:0] sounder_mode_in,
    input wire logic [1:0] op_mode_in,
    input wire logic deep_sleep_in,
    output logic [9:0] button_output_n_out,
    output logic host_driven_output_0_out,
    output logic host_driven_output_1_out,
    output logic sounder_pin_0_out,
    output logic sounder_pin_1_out,
    output logic sleep_out,
    output logic deep_sleep_out
);

    // ****************************************************************
    // Wake line synchroniser
    // ****************************************************************
    logic wake_meta; // First stage, read only by wake_sync
    logic wake_sync; // Usable wake level

    // Two flops before any logic reads the line
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wake_meta <= 1'b1;
            wake_sync <= 1'b1;
        end else begin
            wake_meta <= link.wake_line;
            wake_sync <= wake_meta;
        end
    end

    // ****************************************************************
    // Touch detection per button
    // ****************************************************************
    localparam int CNT_W = touch_pkg::CNT_W; // Long counter width
    logic [9:0] raw_touch; // Shift at or above threshold
    logic [9:0] latched_off; // Forced off, awaiting release
    logic [9:0] held; // Button accepted as on
    logic [9:0] out_state; // Button output, active high
    logic [CNT_W-1:0] stuck_cnt [10]; // Continuous touch time
    wire [CNT_W-1:0] stuck_limit = stuck_long_in ?
        CNT_W'(STUCK_LONG) : CNT_W'(STUCK_SHORT);
    // Auto threshold tracks noise with margin; trades speed for simplicity
    wire [7:0] auto_thresh = (noise_in > 8'h7f) ? 8'hff :
        8'(noise_in + noise_in);
    // Group member held on blocks later group touches
    wire group_busy = |(held & suppress_en_in);

    genvar b;
    generate
        for (b = 0; b < 10; b++) begin : g_btn
            // (RULE13) Threshold compare
            assign raw_touch[b] = shift_in[b] >=
                (auto_thresh_in ? auto_thresh : fixed_thresh_in);
            // Touch may be newly accepted this cycle
            wire rise_ok = raw_touch[b] && !held[b] && !latched_off[b];
            // (RULE15) Suppressed unless group idle and lowest index
            wire allow = !suppress_en_in[b] ||
                (!group_busy && !(|(raw_touch[b:0] & suppress_en_in[b:0]
                & ~(10'(1) << b))));
            wire stuck = held[b] && stuck_cnt[b] >= stuck_limit;

            always_ff @(posedge ref_clk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    held[b] <= 1'b0;
                    latched_off[b] <= 1'b0;
                    stuck_cnt[b] <= '0;
                    out_state[b] <= 1'b0;
                end else begin
                    // (RULE12) Forced release on stuck touch
                    if (stuck) begin
                        held[b] <= 1'b0;
                        latched_off[b] <= 1'b1;
                    // (RULE18) Clear latch only after untouched
                    end else if (!raw_touch[b]) begin
                        held[b] <= 1'b0;
                        latched_off[b] <= 1'b0;
                    // (RULE16) Independent unless in group
                    end else if (rise_ok && allow) begin
                        held[b] <= 1'b1;
                    end
                    // Counter runs only while accepted on
                    if (held[b] && raw_touch[b] && !stuck) begin
                        stuck_cnt[b] <= stuck_cnt[b] + 1'b1;
                    end else begin
                        stuck_cnt[b] <= '0;
                    end
                    // (RULE14) Toggle on rising accepted touch
                    if (toggle_en_in[b]) begin
                        if (rise_ok && allow && !stuck) begin
                            out_state[b] <= ~out_state[b];
                        end
                    end else begin
                        out_state[b] <= held[b] && !stuck;
                    end
                end
            end
        end
    endgenerate

    // (RULE17) Active-low button outputs from flops
    assign button_output_n_out = ~out_state;

    // ****************************************************************
    // Host-driven outputs and power-on pulse
    // ****************************************************************
    logic [3:0] host_out; // Last value written by host
    logic [CNT_W-1:0] pulse_cnt; // Power-on pulse timer
    logic pulse_on; // Pulse still running
    logic ack; // Access acknowledged

    wire mode_ok = op_mode_in != 2'(touch_pkg::MODE_CONFIG);
    // (RULE8) (RULE9) Answer only while wake line held low
    // Not taken again while acking, so ack stays a one-cycle pulse
    wire take = link.i2c_req && !wake_sync && !ack;

    // Holds written value; reset clears volatile settings
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            // (RULE4) Low after reset
            host_out <= touch_pkg::HOST_OUT_RESET;
            pulse_cnt <= '0;
            pulse_on <= 1'b1;
            ack <= 1'b0;
            link.i2c_rdata <= '0;
        end else begin
            ack <= take;
            link.i2c_rdata <= out_state;
            // (RULE3) Writes honoured in allowed modes
            if (take && link.i2c_wr && mode_ok) begin
                host_out <= link.i2c_wdata;
            end
            // (RULE5) 16 ms pulse after reset release
            if (pulse_on) begin
                pulse_cnt <= pulse_cnt + 1'b1;
                if (pulse_cnt >= CNT_W'(PULSE_LEN - 1)) begin
                    pulse_on <= 1'b0;
                end
            end
        end
    end

    assign link.i2c_ack = ack;

    // Sounder pins handed to host per mode; waveform not produced here
    wire pin0_host = sounder_mode_in == 2'(touch_pkg::SOUNDER_NONE);
    wire pin1_host = sounder_mode_in != 2'(touch_pkg::SOUNDER_TWO_PIN);

    // (RULE1) Push-pull levels from last write
    assign host_driven_output_0_out = host_out[0];
    assign host_driven_output_1_out = host_out[1] | pulse_on;
    // (RULE2) Sounder pins as host outputs by mode
    assign sounder_pin_1_out = pin1_host & host_out[2];
    assign sounder_pin_0_out = pin0_host & host_out[3];

    // ****************************************************************
    // Wake line drive and sleep state
    // ****************************************************************
    // (RULE10) (RULE6) Pull low while any touched
    assign link.dev_wake_oe = |held;
    // Sleep reported whenever nobody pulls the line low
    assign sleep_out = wake_sync;
    assign deep_sleep_out = wake_sync & deep_sleep_in;

endmodule : touch_device

/* verilog/touch_host.sv */
// Host end: pulls wake line to read, watches both wake edges.
// Assumes the device end shares the interface and the reference clock.
module touch_host (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    touch_link_if.host link,
    input wire logic read_req_in,
    input wire logic write_req_in,
    input wire logic [3:0] wdata_in,
    output logic [9:0] status_out,
    output logic done_out,
    output logic touch_evt_out,
    output logic release_evt_out
);

    // ****************************************************************
    // Wake line edges
    // ****************************************************************
    logic wake_meta; // First stage only
    logic wake_sync; // Synchronised level
    logic wake_prev; // Previous level for edges

    // (RULE11) Both edges seen
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wake_meta <= 1'b1;
            wake_sync <= 1'b1;
            wake_prev <= 1'b1;
        end else begin
            wake_meta <= link.wake_line;
            wake_sync <= wake_meta;
            wake_prev <= wake_sync;
        end
    end

    assign touch_evt_out = wake_prev & ~wake_sync;
    assign release_evt_out = ~wake_prev & wake_sync;

    // ****************************************************************
    // Access sequence
    // ****************************************************************
    typedef enum logic [1:0] {IDLE, PULL, ACCESS} host_state_e;
    host_state_e state;
    logic wr; // Current access writes
    logic [3:0] wdata; // Held write value
    logic pull; // Wake line pulled low
    logic [1:0] settle; // Wait for device to see low level

    // (RULE7) Pull wake low, then access
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= IDLE;
            wr <= 1'b0;
            wdata <= '0;
            pull <= 1'b0;
            settle <= '0;
            status_out <= '0;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            unique case (state)
                IDLE: begin
                    if (read_req_in || write_req_in) begin
                        wr <= write_req_in;
                        wdata <= wdata_in;
                        pull <= 1'b1;
                        settle <= '0;
                        state <= PULL;
                    end
                end
                PULL: begin
                    settle <= settle + 1'b1;
                    if (settle == 2'h3) begin
                        state <= ACCESS;
                    end
                end
                ACCESS: begin
                    if (link.i2c_ack) begin
                        status_out <= link.i2c_rdata;
                        done_out <= 1'b1;
                        pull <= 1'b0;
                        state <= IDLE;
                    end
                end
            endcase
        end
    end

    // (RULE6) Open-drain pull only
    assign link.host_wake_oe = pull;
    assign link.i2c_req = state == ACCESS;
    assign link.i2c_wr = wr;
    assign link.i2c_wdata = wdata;

endmodule : touch_host

/* bench/touch_link_checker.sv */
// Checker for the touch link: open-drain wake line and host access.
// Assumes both ends share one clock and the async active-low reset.
module touch_link_checker (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic dev_wake_oe,
    input wire logic host_wake_oe,
    input wire logic wake_line,
    input wire logic i2c_req,
    input wire logic i2c_ack
);
    // ****************************************************************
    // Link assertions
    // ****************************************************************
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rstn_in);

    AST_WAKE_WIRED: assert property (
        wake_line == !(dev_wake_oe || host_wake_oe))
        else $error("wake line level wrong");
    AST_REQ_PULLED: assert property (
        i2c_req |-> host_wake_oe && !wake_line)
        else $error("access without wake pull");
    AST_REQ_HELD: assert property (
        i2c_req && !i2c_ack |=> i2c_req && host_wake_oe)
        else $error("access dropped before ack");
    AST_REQ_DROPS: assert property (
        i2c_ack |=> !i2c_req)
        else $error("access held after ack");
    AST_NO_ACK_ASLEEP: assert property (
        i2c_ack |-> !$past(wake_line, 1) && !$past(wake_line, 2))
        else $error("ack while wake high");
    AST_ACK_PULSE: assert property (
        i2c_ack |=> !i2c_ack)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property (
        i2c_ack |-> $past(i2c_req))
        else $error("ack without access");
    AST_ACK_ANSWER: assert property (
        $rose(i2c_req) |-> ##[1:4] i2c_ack)
        else $error("access not answered");
endmodule : touch_link_checker

/* bench/touch_button_output_logic_test.sv */
// Bench joining the device end and the host end over the link.
// Assumes short stuck and pulse counts so that the run stays brief.
module touch_button_output_logic_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // Stimulus and observed signals
    // ****************************************************************
    localparam longint SHORT = 50; // Short stuck-release count
    localparam longint LONG = 200; // Long stuck-release count
    localparam longint PULSE = 20; // Power-on pulse count
    logic ref_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [9:0][7:0] shift_in = '0; // Raw shift per button
    logic [7:0] noise_in = 8'h00;
    logic auto_thresh_in = 1'b0;
    logic [7:0] fixed_thresh_in = 8'h40;
    logic [9:0] toggle_en_in = 10'h000;
    logic [9:0] suppress_en_in = 10'h000;
    logic stuck_long_in = 1'b0;
    logic [1:0] sounder_mode_in = 2'h0;
    logic [1:0] op_mode_in = 2'h0;
    logic deep_sleep_in = 1'b0;
    logic read_req_in = 1'b0;
    logic write_req_in = 1'b0;
    logic [3:0] wdata_in = 4'h0;
    logic [9:0] button_output_n_out, status_out;
    logic host_driven_output_0_out, host_driven_output_1_out;
    logic sounder_pin_0_out, sounder_pin_1_out;
    logic sleep_out, deep_sleep_out, done_out;
    logic touch_evt_out, release_evt_out;
    int failures = 0;
    int checked = 0;
    int n_t = 0; // Touch events seen by the host
    int n_r = 0; // Release events seen by the host
    always #4 ref_clk_in = ~ref_clk_in;
    touch_link_if touch_link_if_inst ();
    wire wake_seen = touch_link_if_inst.wake_line; // Resolved wake level
    touch_device #(.STUCK_SHORT(SHORT), .STUCK_LONG(LONG),
        .PULSE_LEN(PULSE)) touch_device_inst (.ref_clk_in, .rstn_in,
        .link(touch_link_if_inst), .shift_in, .noise_in, .auto_thresh_in,
        .fixed_thresh_in, .toggle_en_in, .suppress_en_in, .stuck_long_in,
        .sounder_mode_in, .op_mode_in, .deep_sleep_in, .button_output_n_out,
        .host_driven_output_0_out, .host_driven_output_1_out,
        .sounder_pin_0_out, .sounder_pin_1_out, .sleep_out, .deep_sleep_out);
    touch_host touch_host_inst (.ref_clk_in, .rstn_in,
        .link(touch_link_if_inst), .read_req_in, .write_req_in, .wdata_in,
        .status_out, .done_out, .touch_evt_out, .release_evt_out);
    touch_link_checker touch_link_checker_inst (.ref_clk_in, .rstn_in,
        .dev_wake_oe(touch_link_if_inst.dev_wake_oe),
        .host_wake_oe(touch_link_if_inst.host_wake_oe),
        .wake_line(touch_link_if_inst.wake_line),
        .i2c_req(touch_link_if_inst.i2c_req),
        .i2c_ack(touch_link_if_inst.i2c_ack));
    // Count one-cycle wake edge pulses of the host
    always @(posedge ref_clk_in) begin
        n_t <= n_t + int'(touch_evt_out === 1'b1);
        n_r <= n_r + int'(release_evt_out === 1'b1);
    end
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input string name, input logic [9:0] e,
        input logic [9:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, e, g);
        end
    endtask : chk
    // Wait, then sample just after the edge once values settle
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask : cyc
    // Touch the masked buttons with the given shift
    task automatic press(input logic [9:0] m, input logic [7:0] v = 8'hff);
        @(posedge ref_clk_in);
        for (int i = 0; i < 10; i++) shift_in[i] <= m[i] ? v : 8'h00;
        cyc(8);
    endtask : press
    // One host read or write, waiting a bounded time for completion
    task automatic access(input logic wr, input logic [3:0] d);
        int n;
        n = 0;
        @(posedge ref_clk_in);
        read_req_in <= !wr;
        write_req_in <= wr;
        wdata_in <= d;
        @(posedge ref_clk_in);
        read_req_in <= 1'b0;
        write_req_in <= 1'b0;
        while (done_out !== 1'b1 && n < 40) begin
            cyc(1);
            n++;
        end
        chk("done", 10'h001, {9'h0, done_out});
        cyc(1);
    endtask : access
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // power-on levels
    task automatic t_power();
        cyc(11);
        chk("pulse reset", 10'h001, {9'h0, host_driven_output_1_out});
        @(posedge ref_clk_in);
        rstn_in <= 1'b1;
        cyc(int'(PULSE) - 4);
        chk("pulse held", 10'h001, {9'h0, host_driven_output_1_out});
        cyc(10);
        chk("host outs", 10'h000, {6'h0, sounder_pin_0_out, sounder_pin_1_out,
            host_driven_output_1_out, host_driven_output_0_out});
        chk("buttons off", 10'h3ff, button_output_n_out);
        chk("asleep", 10'h001, {9'h0, sleep_out});
    endtask : t_power
    task automatic t_host_out();
        logic [3:0] cur, mask, d;
        cur = 4'h0;
        for (int m = 0; m < 3; m++) begin
            mask = (m == 0) ? 4'hf : (m == 1) ? 4'h7 : 4'h3;
            for (int o = 0; o < 4; o++) begin
                for (int p = 0; p < 2; p++) begin
                    d = p ? 4'ha : 4'h5;
                    sounder_mode_in <= m[1:0];
                    op_mode_in <= o[1:0];
                    access(1'b1, d);
                    if (o != 3) cur = d;
                    chk("host outs", {6'h0, cur & mask}, {6'h0,
                        sounder_pin_0_out, sounder_pin_1_out,
                        host_driven_output_1_out,
                        host_driven_output_0_out});
                end
            end
        end
        op_mode_in <= 2'h0;
    endtask : t_host_out
    // settings lost on a mid-run reset
    task automatic t_rereset();
        access(1'b1, 4'hf);
        @(posedge ref_clk_in);
        rstn_in <= 1'b0;
        cyc(3);
        chk("outs in reset", 10'h002, {6'h0, sounder_pin_0_out,
            sounder_pin_1_out, host_driven_output_1_out,
            host_driven_output_0_out});
        @(posedge ref_clk_in);
        rstn_in <= 1'b1;
        cyc(int'(PULSE) + 10);
        chk("outs after reset", 10'h000, {6'h0, sounder_pin_0_out,
            sounder_pin_1_out, host_driven_output_1_out,
            host_driven_output_0_out});
    endtask : t_rereset
    task automatic t_wake();
        int t0, r0;
        t0 = n_t;
        r0 = n_r;
        deep_sleep_in <= 1'b1;
        cyc(4);
        chk("deep sleep", 10'h001, {9'h0, deep_sleep_out});
        press(10'h208);
        chk("buttons", 10'h1f7, button_output_n_out);
        chk("wake low", 10'h000, {9'h0, wake_seen});
        chk("awake", 10'h000, {9'h0, sleep_out});
        access(1'b0, 4'h0);
        chk("status", 10'h208, status_out);
        press(10'h000);
        chk("wake high", 10'h001, {9'h0, wake_seen});
        chk("edges", 10'h021, {5'(n_t - t0), 5'(n_r - r0)});
        access(1'b0, 4'h0);
        chk("status clear", 10'h000, status_out);
        deep_sleep_in <= 1'b0;
    endtask : t_wake
    task automatic t_stuck(input logic lng);
        int lim;
        lim = lng ? int'(LONG) : int'(SHORT);
        stuck_long_in <= lng;
        press(10'h001);
        cyc(lim - 20);
        chk("stuck held", 10'h3fe, button_output_n_out);
        cyc(40);
        chk("stuck off", 10'h3ff, button_output_n_out);
        cyc(20);
        chk("stays off", 10'h3ff, button_output_n_out);
        press(10'h000);
        press(10'h001);
        chk("retouch", 10'h3fe, button_output_n_out);
        press(10'h000);
    endtask : t_stuck
    task automatic t_features();
        toggle_en_in <= 10'h020;
        press(10'h020);
        press(10'h000);
        chk("toggle on", 10'h3df, button_output_n_out);
        press(10'h020);
        press(10'h000);
        chk("toggle off", 10'h3ff, button_output_n_out);
        toggle_en_in <= 10'h000;
        suppress_en_in <= 10'h006;
        press(10'h004);
        press(10'h006);
        chk("first wins", 10'h3fb, button_output_n_out);
        press(10'h000);
        press(10'h186);
        chk("group apart", 10'h27d, button_output_n_out);
        press(10'h000);
        press(10'h010, 8'h50);
        chk("fixed thr", 10'h3ef, button_output_n_out);
        auto_thresh_in <= 1'b1;
        noise_in <= 8'h30;
        cyc(8);
        chk("auto thr", 10'h3ff, button_output_n_out);
        press(10'h000);
        auto_thresh_in <= 1'b0;
    endtask : t_features
    // ****************************************************************
    // Verdict and sequencing
    // ****************************************************************
    task automatic report_and_stop();
        if (failures == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop
    // Watchdog well beyond the roughly 900 cycles of the tests
    initial begin
        repeat (20000) @(posedge ref_clk_in);
        failures++;
        report_and_stop();
    end
    initial begin
        t_power();
        t_host_out();
        t_rereset();
        t_wake();
        t_stuck(1'b0);
        t_stuck(1'b1);
        t_features();
        report_and_stop();
    end
endmodule : touch_button_output_logic_test
